/* core/rvs_pkg.sv */
// Shared constants for the supply control register bank
//
// Summary of operation
// - Voltage input field 6:5 decodes sequencer, inputs 1-3
// - Step-down input edges switch between settings B and A
// - Linear regulator input edges switch settings B and A
// - Enable input field 2:1 edges enable or disable
// - Enable field decode matches voltage field decode
// - Step-down bit 0 requests converter off or on
// - Linear regulator bit 0 requests regulator off or on
// - Config bit keeps sequenced supply on in low power
// - Linear regulator bit 3 disables output pull-down
// - Per-input programmable active level judges transitions
// - Separate choice bit picks setting A or B
package rvs_pkg;

    // ----------------------------------------------------------------
    // Register port geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W = 10;         // Register address width
    localparam int DATA_W = 8;          // Register data width
    localparam int NUM_SUP = 4;         // Supplies handled here
    localparam int NUM_IN = 3;          // General-purpose inputs

    // ----------------------------------------------------------------
    // Register offsets (supply order: stepdown4, stepdown3, linreg1, linreg2)
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] STEPDOWN4_SUPPLY_CTRL = 10'h022;
    localparam logic [ADDR_W-1:0] STEPDOWN3_SUPPLY_CTRL = 10'h024;
    localparam logic [ADDR_W-1:0] LINREG1_SUPPLY_CTRL = 10'h026;
    localparam logic [ADDR_W-1:0] LINREG2_SUPPLY_CTRL = 10'h027;
    localparam logic [ADDR_W-1:0] SUPPLY_SETTING_CHOICE = 10'h032;
    localparam logic [ADDR_W-1:0] CTRL_ADDR [NUM_SUP] = '{
        STEPDOWN4_SUPPLY_CTRL, STEPDOWN3_SUPPLY_CTRL,
        LINREG1_SUPPLY_CTRL, LINREG2_SUPPLY_CTRL};

    // ----------------------------------------------------------------
    // Field positions in the control registers
    // ----------------------------------------------------------------
    localparam int EN_POS = 0;          // On request
    localparam int ENSEL_LSB = 1;       // Enable input select 2:1
    localparam int SEL_W = 2;           // Width of both select fields
    localparam int SD_CONF_POS = 3;     // Step-down sequence config
    localparam int LR_PD_POS = 3;       // Linear regulator pull-down off
    localparam int VSEL_LSB = 5;        // Voltage input select 6:5
    localparam int LR_CONF_POS = 7;     // Linear regulator sequence config
    localparam int CONF_POS [NUM_SUP] = '{SD_CONF_POS, SD_CONF_POS,
        LR_CONF_POS, LR_CONF_POS};
    localparam int FIRST_LINREG = 2;    // Index of linreg1

    // Writable bits; reserved bits hold zero and read back as zero
    localparam logic [DATA_W-1:0] SD_WMASK = 8'h6f;
    localparam logic [DATA_W-1:0] LR_WMASK = 8'hef;
    localparam logic [DATA_W-1:0] CTRL_WMASK [NUM_SUP] = '{SD_WMASK,
        SD_WMASK, LR_WMASK, LR_WMASK};
    localparam logic [DATA_W-1:0] CTRL_RST = 8'h00;

    // Position of each supply's bit in the setting choice register
    localparam int CHOICE_POS [NUM_SUP] = '{2, 3, 4, 5};
    localparam logic [NUM_SUP-1:0] CHOICE_RST = 4'h0;

    // ----------------------------------------------------------------
    // Input source selection encoding
    // ----------------------------------------------------------------
    typedef enum logic [SEL_W-1:0] {
        SRC_SEQ = 2'h0,
        SRC_IN1 = 2'h1,
        SRC_IN2 = 2'h2,
        SRC_IN3 = 2'h3
    } rvs_src_t;

endpackage

/* core/rvs_input_edge.sv */
// Input synchroniser and active-level edge detector for one pin
module rvs_input_edge (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic pinIn,
    input wire logic activeHigh,
    output logic goActive,
    output logic goPassive
);
    import rvs_pkg::*;

    // ----------------------------------------------------------------
    // Synchroniser
    // ----------------------------------------------------------------
    logic meta_q;       // First stage, read only by the second
    logic sync_q;       // Settled pin level
    logic prev_q;       // Level one cycle earlier

    // Two flops before anything looks at the pin
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= pinIn;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // ----------------------------------------------------------------
    // Edge events
    // ----------------------------------------------------------------
    // Edges are taken on the raw level and then mapped by polarity, so a
    // change of the polarity setting alone never fakes a transition
    always_comb begin
        goActive = activeHigh ? (sync_q & ~prev_q) : (~sync_q & prev_q);
        goPassive = activeHigh ? (~sync_q & prev_q) : (sync_q & ~prev_q);
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // Events last exactly one cycle
    single_pulse_a: assert property (goActive |=> !goActive)
        else $error("activation event lasted more than one cycle");

    // Activation tracks the programmed level
    level_polarity_a: assert property (goActive |-> sync_q == activeHigh)
        else $error("activation event against active level");

endmodule

/* core/rvs_supply_regs.sv */
// Supply enable and voltage setting control registers
module rvs_supply_regs (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [rvs_pkg::ADDR_W-1:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [rvs_pkg::DATA_W-1:0] regWrData,
    output logic [rvs_pkg::DATA_W-1:0] regRdData_q,
    input wire logic generalInputOne,
    input wire logic generalInputTwo,
    input wire logic generalInputThree,
    input wire logic [rvs_pkg::NUM_IN-1:0] inputActiveLevel,
    input wire logic lowPowerState,
    output logic [rvs_pkg::NUM_SUP-1:0] supplyOn_q,
    output logic [rvs_pkg::NUM_SUP-1:0] settingB_q,
    output logic [1:0] pulldownActive_q
);
    import rvs_pkg::*;

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] ctrl_q [NUM_SUP];    // Control registers
    logic [NUM_SUP-1:0] supplyOn_d;         // Next on state per supply
    logic [1:0] pulldownActive_d;           // Next pull-down state

    // ----------------------------------------------------------------
    // Input event detection
    // ----------------------------------------------------------------
    logic [NUM_IN-1:0] pinVec;      // Pins gathered in order one..three
    logic [NUM_IN-1:0] riseEvt;     // Passive-to-active events
    logic [NUM_IN-1:0] fallEvt;     // Active-to-passive events

    assign pinVec = {generalInputThree, generalInputTwo, generalInputOne};

    // One synchroniser and edge detector per input pin
    for (genvar g = 0; g < NUM_IN; g++) begin : gInput
        rvs_input_edge uEdge (
            .clk(clk),
            .sys_rst(sys_rst),
            .pinIn(pinVec[g]),
            .activeHigh(inputActiveLevel[g]),
            .goActive(riseEvt[g]),
            .goPassive(fallEvt[g])
        );
    end

    // Pick the event of the input a select field names; sequencer gives none
    function automatic logic pickEvt(input logic [SEL_W-1:0] sel,
                                     input logic [NUM_IN-1:0] evt);
        case (rvs_src_t'(sel))
            SRC_IN1: pickEvt = evt[0];
            SRC_IN2: pickEvt = evt[1];
            SRC_IN3: pickEvt = evt[2];
            default: pickEvt = 1'b0;    // Sequencer owns the bit
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Per-supply event routing
    // ----------------------------------------------------------------
    logic [NUM_SUP-1:0] enOnEvt;    // Enable input went active
    logic [NUM_SUP-1:0] enOffEvt;   // Enable input went passive
    logic [NUM_SUP-1:0] volBEvt;    // Voltage input went active
    logic [NUM_SUP-1:0] volAEvt;    // Voltage input went passive

    // Decode both select fields with the same source table
    always_comb begin
        for (int i = 0; i < NUM_SUP; i++) begin
            enOnEvt[i] = pickEvt(ctrl_q[i][ENSEL_LSB +: SEL_W], riseEvt);
            enOffEvt[i] = pickEvt(ctrl_q[i][ENSEL_LSB +: SEL_W], fallEvt);
            volBEvt[i] = pickEvt(ctrl_q[i][VSEL_LSB +: SEL_W], riseEvt);
            volAEvt[i] = pickEvt(ctrl_q[i][VSEL_LSB +: SEL_W], fallEvt);
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    // Host writes land first; an input event in the same cycle wins on the
    // on bit, so a transition is never lost behind a host write
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < NUM_SUP; i++) begin
                ctrl_q[i] <= CTRL_RST;
            end
        end else begin
            for (int i = 0; i < NUM_SUP; i++) begin
                if (regWrite && regAddr == CTRL_ADDR[i]) begin
                    ctrl_q[i] <= regWrData & CTRL_WMASK[i];
                end
                if (enOnEvt[i]) begin
                    ctrl_q[i][EN_POS] <= 1'b1;
                end else if (enOffEvt[i]) begin
                    ctrl_q[i][EN_POS] <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Setting choice register (A = 0, B = 1)
    // ----------------------------------------------------------------
    // The output flops are the register itself; input events override a
    // host write in the same cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            settingB_q <= CHOICE_RST;
        end else begin
            for (int i = 0; i < NUM_SUP; i++) begin
                if (regWrite && regAddr == SUPPLY_SETTING_CHOICE) begin
                    settingB_q[i] <= regWrData[CHOICE_POS[i]];
                end
                if (volBEvt[i]) begin
                    settingB_q[i] <= 1'b1;
                end else if (volAEvt[i]) begin
                    settingB_q[i] <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Supply on requests and pull-down control
    // ----------------------------------------------------------------
    // The on/off priority ordering lives in the sequencer downstream; this
    // block only presents the request. In low power only sequenced supplies
    // keep their request.
    always_comb begin
        for (int i = 0; i < NUM_SUP; i++) begin
            supplyOn_d[i] = ctrl_q[i][EN_POS]
                & (~lowPowerState | ctrl_q[i][CONF_POS[i]]);
        end
        for (int k = 0; k < 2; k++) begin
            pulldownActive_d[k] = ~supplyOn_d[FIRST_LINREG + k]
                & ~ctrl_q[FIRST_LINREG + k][LR_PD_POS];
        end
    end

    // Outputs leave straight from flops
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            supplyOn_q <= '0;
            pulldownActive_q <= '0;
        end else begin
            supplyOn_q <= supplyOn_d;
            pulldownActive_q <= pulldownActive_d;
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] rdMux;       // Selected read value

    // Unmapped offsets read as zero
    always_comb begin
        rdMux = '0;
        for (int i = 0; i < NUM_SUP; i++) begin
            if (regAddr == CTRL_ADDR[i]) begin
                rdMux = ctrl_q[i];
            end
            if (regAddr == SUPPLY_SETTING_CHOICE) begin
                rdMux[CHOICE_POS[i]] = settingB_q[i];
            end
        end
    end

    // Read data is held until the next read strobe
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            regRdData_q <= '0;
        end else if (regRead) begin
            regRdData_q <= rdMux;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    logic wrCtrl0;      // Host writes stepdown4 control this cycle
    logic wrChoice;     // Host writes the choice register this cycle
    assign wrCtrl0 = regWrite && regAddr == STEPDOWN4_SUPPLY_CTRL;
    assign wrChoice = regWrite && regAddr == SUPPLY_SETTING_CHOICE;

    voltage_decode_a: assert property (
        riseEvt[1] && ctrl_q[0][VSEL_LSB +: SEL_W] == SRC_IN2 |=> settingB_q[0])
        else $error("voltage select input two did not pick setting B");

    stepdown_return_a: assert property (
        volAEvt[1] |=> !settingB_q[1])
        else $error("step-down did not return to setting A");

    // Setting B must still stand two cycles on unless a clear came between
    linreg_to_b_a: assert property (
        volBEvt[2] |=> settingB_q[2] ##2 (settingB_q[2] || $past(volAEvt[2])
        || $past(volAEvt[2], 2) || $past(wrChoice) || $past(wrChoice, 2)))
        else $error("linear regulator did not move to setting B");

    enable_edge_a: assert property (
        enOnEvt[0] |=> ctrl_q[0][EN_POS] ##1 supplyOn_q[0] || $past(lowPowerState))
        else $error("enable input edge did not turn the supply on");

    seq_owns_a: assert property (
        ctrl_q[0][ENSEL_LSB +: SEL_W] == SRC_SEQ && !wrCtrl0
        |=> $stable(ctrl_q[0][EN_POS]))
        else $error("enable bit moved while the sequencer owns it");

    stepdown_on_a: assert property (
        ctrl_q[1][EN_POS] && !lowPowerState |=> supplyOn_q[1])
        else $error("step-down on bit not reflected");

    linreg_off_a: assert property (
        !ctrl_q[3][EN_POS] |=> !supplyOn_q[3] && pulldownActive_q[1]
        == !$past(ctrl_q[3][LR_PD_POS]))
        else $error("linear regulator off request not reflected");

    low_power_a: assert property (
        lowPowerState && ctrl_q[2][EN_POS] |=>
        supplyOn_q[2] == $past(ctrl_q[2][LR_CONF_POS]))
        else $error("low power state handling wrong for linear regulator");

    pulldown_ctrl_a: assert property (
        supplyOn_q[2] |-> !pulldownActive_q[0])
        else $error("pull-down active while regulator on");

    choice_write_a: assert property (
        wrChoice && volBEvt == '0 && volAEvt == '0 |=>
        settingB_q[1] == $past(regWrData[CHOICE_POS[1]]))
        else $error("setting choice write lost");

    event_single_a: assert property (
        $rose(enOnEvt[3]) |=> !enOnEvt[3])
        else $error("enable event longer than one cycle");

    // Input three on the enable field turns linreg2 on
    input_three_a: assert property (
        riseEvt[2] && ctrl_q[3][ENSEL_LSB +: SEL_W] == SRC_IN3 |=> ctrl_q[3][EN_POS])
        else $error("enable select input three did not turn the supply on");

    // A passive edge on the enable input clears the on bit
    disable_edge_a: assert property (
        enOffEvt[2] |=> !ctrl_q[2][EN_POS])
        else $error("enable input edge did not turn the supply off");

    // Sequencer code on the voltage field blocks every pin event
    seq_voltage_a: assert property (
        ctrl_q[1][VSEL_LSB +: SEL_W] == SRC_SEQ |-> !volBEvt[1] && !volAEvt[1])
        else $error("voltage event while the sequencer owns the choice");

    // Step-down moves to setting B on an active edge
    stepdown_to_b_a: assert property (
        volBEvt[0] |=> settingB_q[0])
        else $error("step-down did not move to setting B");

    // Linear regulator falls back to setting A on a passive edge
    linreg_return_a: assert property (
        volAEvt[3] |=> !settingB_q[3])
        else $error("linear regulator did not return to setting A");

    // A default supply drops its request in low power whatever its on bit;
    // the bit itself is kept so the supply returns when low power ends
    lowpower_drop_a: assert property (
        lowPowerState && !ctrl_q[0][SD_CONF_POS] |=> !supplyOn_q[0])
        else $error("default supply kept on in low power");

    // Pull-down stays off for an off regulator when its off bit is set
    pulldown_off_a: assert property (
        !supplyOn_d[3] && ctrl_q[3][LR_PD_POS] |=> !pulldownActive_q[1])
        else $error("pull-down active although disabled");

    // Linear regulator on bit reaches its request outside low power
    linreg_on_a: assert property (
        ctrl_q[2][EN_POS] && !lowPowerState |=> supplyOn_q[2])
        else $error("linear regulator on bit not reflected");

    // Choice register reads back each supply at its own bit, zeros elsewhere
    choice_read_a: assert property (
        regRead && regAddr == SUPPLY_SETTING_CHOICE
        |=> regRdData_q == {2'b00, $past(settingB_q), 2'b00})
        else $error("setting choice read back wrong");

    // A second enable event on the next cycle needs a fresh select write,
    // since one synchronised pin cannot make two edges in a row
    event_pulse_a: assert property (
        enOnEvt[0] |=> !enOnEvt[0] || $past(wrCtrl0))
        else $error("enable event repeated without a select change");

    // ----------------------------------------------------------------
    // Cover points for the main scenarios
    // ----------------------------------------------------------------
    enable_cover: cover property (enOnEvt[0] ##[1:20] enOffEvt[0]);
    voltage_cover: cover property (volBEvt[2] ##[1:20] volAEvt[2]);
    lowpower_cover: cover property (supplyOn_q[3] ##1 lowPowerState && !supplyOn_q[3]);
    collide_cover: cover property (wrChoice && volBEvt[1]);
    stepdown_cover: cover property (volBEvt[0] ##[1:20] volAEvt[0]);

endmodule

/* bench/rvs_host_model.sv */
// Host register-port and input-pin model facing the supply register bank
module rvs_host_model (
    input wire logic clk,
    input wire logic [rvs_pkg::DATA_W-1:0] regRdData_q,
    output logic [rvs_pkg::ADDR_W-1:0] regAddr,
    output logic regWrite,
    output logic regRead,
    output logic [rvs_pkg::DATA_W-1:0] regWrData,
    output logic [rvs_pkg::NUM_IN-1:0] pins
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Idle bus and passive pins at time zero
    // ------------------------------------------------------------
    initial begin
        regAddr = '0;
        regWrite = 1'b0;
        regRead = 1'b0;
        regWrData = '0;
        pins = '0;
    end

    // Single-byte write; data is scrambled once released
    task automatic wr(input logic [9:0] addr, input logic [7:0] data);
        @(posedge clk);
        #1 regAddr = addr;
        regWrite = 1'b1;
        regWrData = data;
        @(posedge clk);
        #1 regWrite = 1'b0;
        regWrData = ~data;
    endtask

    // Single-byte read; data is valid just after the edge that takes the read strobe
    task automatic rd(input logic [9:0] addr, output logic [7:0] data);
        @(posedge clk);
        #1 regAddr = addr;
        regRead = 1'b1;
        @(posedge clk);
        #1 regRead = 1'b0;
        data = regRdData_q;
    endtask

    // Pins change just after an edge, never twice in one step
    task automatic pin(input int idx, input logic val);
        @(posedge clk);
        #1 pins[idx] = val;
    endtask

    // Whole pin vector at once, for moving the idle levels; the caller is
    // already just past an edge, so no wait is taken here
    task automatic pinsAll(input logic [2:0] val);
        pins = val;
    endtask
endmodule

/* bench/rvs_supply_regs_bench.sv */
// Self-checking bench for the supply control register bank
module rvs_supply_regs_bench import rvs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Stimulus and observation signals
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic sys_rst = 1'b1; // Held through the first five edges
    logic [ADDR_W-1:0] regAddr;
    logic regWrite;
    logic regRead;
    logic [DATA_W-1:0] regWrData;
    logic [DATA_W-1:0] regRdData_q;
    logic [NUM_IN-1:0] pins;
    logic [NUM_IN-1:0] inputActiveLevel = 3'h7;
    logic lowPowerState = 1'b0;
    logic [NUM_SUP-1:0] supplyOn_q;
    logic [NUM_SUP-1:0] settingB_q;
    logic [1:0] pulldownActive_q;
    int errCount = 0;
    int numChecks = 0;
    int cycles = 0;

    always #2.5 clk = ~clk;

    rvs_host_model host_u (.clk(clk), .regRdData_q(regRdData_q), .regAddr(regAddr),
        .regWrite(regWrite), .regRead(regRead), .regWrData(regWrData), .pins(pins));

    rvs_supply_regs dut_u (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
        .regWrite(regWrite), .regRead(regRead), .regWrData(regWrData),
        .regRdData_q(regRdData_q), .generalInputOne(pins[0]),
        .generalInputTwo(pins[1]), .generalInputThree(pins[2]),
        .inputActiveLevel(inputActiveLevel), .lowPowerState(lowPowerState),
        .supplyOn_q(supplyOn_q), .settingB_q(settingB_q),
        .pulldownActive_q(pulldownActive_q));

    // ------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", numChecks, errCount);
        if (errCount == 0 && numChecks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Hang guard: the whole run needs well under this many cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 8000) begin
            errCount++;
            $display("ERROR timeout expected finish seen hang");
            end_of_test();
        end
    end

    task automatic chkReg(input string what, input logic [7:0] exp, input logic [7:0] got);
        numChecks++;
        if (got !== exp) begin
            errCount++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chkOut(input string what, input logic [3:0] exp, input logic [3:0] got);
        numChecks++;
        if (got !== exp) begin
            errCount++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rdChk(input logic [9:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        host_u.rd(addr, d);
        chkReg("readback", exp, d);
    endtask

    // Lets the synchroniser, edge flop and output flop all settle
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Reset state: all registers clear, supplies off, pull-downs on
    task automatic scnReset();
        for (int s = 0; s < NUM_SUP; s++)
            rdChk(CTRL_ADDR[s], CTRL_RST);
        rdChk(SUPPLY_SETTING_CHOICE, 8'h00);
        chkOut("supplyOn", 4'h0, supplyOn_q);
        chkOut("pulldown", 4'h3, {2'b00, pulldownActive_q});
    endtask

    // Every input selected by both fields, both active levels
    task automatic scnPins();
        logic [7:0] v;
        logic [2:0] lvl;
        for (int s = 0; s < NUM_SUP; s++) begin
            // Odd supplies run with active-low pins to cover both levels
            lvl = s[0] ? 3'h0 : 3'h7;
            inputActiveLevel = lvl;
            host_u.pinsAll(~lvl);
            settle(6);
            for (int src = 1; src <= NUM_IN; src++) begin
                v = {1'b0, 2'(src), 2'b00, 2'(src), 1'b0};
                host_u.wr(CTRL_ADDR[s], v);
                host_u.pin(src - 1, lvl[src-1]);
                settle(6);
                chkOut("supplyOn", 4'h1 << s, supplyOn_q);
                chkOut("settingB", 4'h1 << s, settingB_q);
                chkOut("pulldown", 4'(2'h3 & ~(s >= 2 ? 2'(1 << (s - 2)) : 2'h0)),
                    {2'b00, pulldownActive_q});
                rdChk(CTRL_ADDR[s], v | 8'h01);
                host_u.pin(src - 1, ~lvl[src-1]);
                settle(6);
                chkOut("supplyOn", 4'h0, supplyOn_q);
                chkOut("settingB", 4'h0, settingB_q);
            end
            // Sequencer decode: the pin must be ignored
            host_u.wr(CTRL_ADDR[s], 8'h00);
            host_u.pin(0, lvl[0]);
            settle(6);
            chkOut("supplyOn", 4'h0, supplyOn_q);
            chkOut("settingB", 4'h0, settingB_q);
            host_u.pin(0, ~lvl[0]);
            settle(6);
        end
    endtask

    // Writable masks, choice register and an unmapped offset
    task automatic scnMask();
        for (int s = 0; s < NUM_SUP; s++) begin
            host_u.wr(CTRL_ADDR[s], 8'hff);
            rdChk(CTRL_ADDR[s], CTRL_WMASK[s]);
        end
        settle(2);
        chkOut("supplyOn", 4'hf, supplyOn_q);
        chkOut("pulldown", 4'h0, {2'b00, pulldownActive_q});
        host_u.wr(SUPPLY_SETTING_CHOICE, 8'hff);
        rdChk(SUPPLY_SETTING_CHOICE, 8'h3c);
        settle(2);
        chkOut("settingB", 4'hf, settingB_q);
        host_u.wr(10'h025, 8'hff);
        rdChk(10'h025, 8'h00);
        host_u.wr(SUPPLY_SETTING_CHOICE, 8'h00);
        for (int s = 0; s < NUM_SUP; s++)
            host_u.wr(CTRL_ADDR[s], 8'h00);
    endtask

    // Low power keeps only sequenced supplies on
    task automatic scnLowPower();
        @(posedge clk);
        #1 lowPowerState = 1'b1;
        // Linear regulators also set their pull-down off bit while held off
        for (int s = 0; s < NUM_SUP; s++)
            host_u.wr(CTRL_ADDR[s], 8'h01 | (s >= FIRST_LINREG ? 8'h01 << LR_PD_POS : 8'h00));
        settle(2);
        chkOut("supplyOn", 4'h0, supplyOn_q);
        chkOut("pulldown", 4'h0, {2'b00, pulldownActive_q});
        for (int s = 0; s < NUM_SUP; s++)
            host_u.wr(CTRL_ADDR[s], 8'h01 | (8'h01 << CONF_POS[s]));
        settle(2);
        chkOut("supplyOn", 4'hf, supplyOn_q);
        lowPowerState = 1'b0;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        #1 sys_rst = 1'b0;
        scnReset();
        scnPins();
        scnMask();
        scnLowPower();
        end_of_test();
    end
endmodule
